// >>> bench/ccpc_video_src.sv
// ccpc_video_src: video source model making line and frame sync
`timescale 1ns/1ps
module ccpc_video_src (
  // clock
  input wire logic clk,
  // enables from the bench
  input wire logic lines_on,
  input wire logic frames_on,
  // sync pins
  output logic line_sync,
  output logic frame_sync
);
  // ------------------------------------------------------------
  // 40-cycle lines, 12 lines a frame, frame sync on lines 0 and 1
  // ------------------------------------------------------------
  logic [5:0] cyc = 6'h00;
  logic [3:0] line = 4'h0;
  initial line_sync = 1'b0;
  initial frame_sync = 1'b0;
  always @(posedge clk) begin
    cyc <= (cyc == 6'h27) ? 6'h00 : cyc + 6'h01;
    if (cyc == 6'h27) begin
      line <= (line == 4'hB) ? 4'h0 : line + 4'h1;
    end
    line_sync <= lines_on && (cyc < 6'h04);
    // idle source holds sync low, no stale edges
    frame_sync <= frames_on && (line < 4'h2);
  end
endmodule : ccpc_video_src

// >>> bench/clamp_coast_power_control_test.sv
// clamp_coast_power_control_test: register and pin checks of ccpc_top
`timescale 1ns/1ps
module clamp_coast_power_control_test;
  import ccpc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic green = 1'b0;
  logic clamp_in = 1'b0;
  logic coast_in = 1'b0;
  logic lines_on = 1'b0;
  logic frames_on = 1'b0;
  logic line_sync;
  logic frame_sync;
  ccpc_vout_t vin = 52'hA_5A5A_5A5A_5A5A;
  ccpc_vout_t vo;
  ccpc_vout_t voe;
  logic gso, clamp_act, red_sel, blue_sel, coast, sep, seek, pdown;
  logic [4:0] code;
  logic [7:0] rd;
  logic er;
  int fail_count = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  ccpc_video_src SRC (.clk(clk), .lines_on(lines_on), .frames_on(frames_on),
    .line_sync(line_sync), .frame_sync(frame_sync));
  // idle span above the 36-cycle gap between line pulses, so live lines never look idle
  ccpc_top #(.IDLE_CYCLES(100)) DUT (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINE_SYNC_IN(line_sync), .FRAME_SYNC_IN(frame_sync),
    .GREEN_SYNC_INPUT(green), .CLAMP_IN(clamp_in), .COAST_IN(coast_in), .VOUT_IN(vin),
    .VOUT_O(vo), .VOUT_OE(voe), .GREEN_SYNC_OUTPUT(gso), .CLAMP_ACTIVE(clamp_act),
    .RED_MIDSCALE_REF_SEL(red_sel), .BLUE_MIDSCALE_REF_SEL(blue_sel), .SLICER_CODE(code),
    .PLL_COAST(coast), .SEP_SYNC_OUT(sep), .SEEK_MODE(seek), .FULL_POWER_DOWN(pdown));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rc(input logic [7:0] idx, input logic [7:0] e, input string nm);
    apb(1'b0, idx, 8'h00);
    chk(nm, e, rd);
  endtask : rc
  task automatic oe(input logic e);
    chk("oe", {7'h00, e}, {7'h00, (voe === 52'hF_FFFF_FFFF_FFFF)});
    chk("oe0", {7'h00, !e}, {7'h00, (voe === 52'h0)});
  endtask : oe
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    cyc(5);
    nrst <= 1'b1;
    rc(IDX_CTRL, RST_CTRL, "ctrl");
    rc(IDX_SLICE, RST_SLICE, "slice");
    rc(IDX_SEPLIM, 8'h20, "seplim");
    rc(IDX_LEAD, 8'h00, "lead");
    rc(IDX_TRAIL, 8'h00, "trail");
    chk("vout", 8'h5A, vo[7:0]);
    apb(1'b1, IDX_CTRL, 8'hFF);
    rc(IDX_CTRL, 8'hFE, "ctrl bit0");
    apb(1'b1, IDX_SLICE, 8'hFF);
    rc(IDX_SLICE, 8'hFE, "slice bit0");
    chk("code", 8'h1F, {3'h0, code});
    chk("refsel", 8'h03, {6'h00, red_sel, blue_sel});
    apb(1'b1, IDX_SLICE, 8'h04);
    chk("refsel", 8'h02, {6'h00, red_sel, blue_sel});
    apb(1'b1, 8'h20, 8'h55);
    chk("slverr", 8'h01, {7'h00, er});
    // separator limit 3: toggles on the fourth tick after the input differs
    apb(1'b1, IDX_SEPLIM, 8'h03);
    green <= 1'b1;
    cyc(70);
    chk("sep early", 8'h00, {7'h00, sep});
    cyc(20);
    chk("sep", 8'h01, {7'h00, sep});
    apb(1'b1, IDX_CTRL, 8'h00);
    cyc(8);
    chk("pdown", 8'h01, {7'h00, pdown});
    oe(1'b0);
    chk("gso", 8'h01, {7'h00, gso});
    apb(1'b1, IDX_CTRL, 8'h06);
    cyc(80);
    chk("seek", 8'h01, {7'h00, seek});
    oe(1'b0);
    lines_on <= 1'b1;
    cyc(60);
    chk("seek exit", 8'h00, {7'h00, seek});
    oe(1'b1);
    lines_on <= 1'b0;
    apb(1'b1, IDX_CTRL, 8'h02);
    cyc(80);
    chk("no seek", 8'h00, {7'h00, seek});
    lines_on <= 1'b1;
    // internal window opens 8 after line start, lasts 20
    @(posedge line_sync);
    cyc(20);
    chk("int clamp", 8'h01, {7'h00, clamp_act});
    cyc(18);
    chk("int clamp off", 8'h00, {7'h00, clamp_act});
    apb(1'b1, IDX_CTRL, 8'h82);
    @(posedge line_sync);
    cyc(20);
    chk("ext clamp low", 8'h00, {7'h00, clamp_act});
    clamp_in <= 1'b1;
    cyc(8);
    chk("ext clamp", 8'h01, {7'h00, clamp_act});
    apb(1'b1, IDX_CTRL, 8'hC2);
    cyc(8);
    chk("clamp inv", 8'h00, {7'h00, clamp_act});
    apb(1'b1, IDX_CTRL, 8'h1A);
    coast_in <= 1'b1;
    cyc(8);
    chk("coast hi", 8'h01, {7'h00, coast});
    apb(1'b1, IDX_CTRL, 8'h12);
    cyc(8);
    chk("coast lo", 8'h00, {7'h00, coast});
    coast_in <= 1'b0;
    cyc(8);
    chk("coast lo act", 8'h01, {7'h00, coast});
    apb(1'b1, IDX_LEAD, 8'h02);
    apb(1'b1, IDX_TRAIL, 8'h02);
    apb(1'b1, IDX_CTRL, 8'h22);
    frames_on <= 1'b1;
    repeat (3) @(posedge frame_sync);
    @(posedge frame_sync);
    chk("pre coast", 8'h01, {7'h00, coast});
    @(negedge frame_sync);
    cyc(30);
    chk("post coast", 8'h01, {7'h00, coast});
    cyc(100);
    chk("coast end", 8'h00, {7'h00, coast});
    // lead 2: line 9 stays clear, line 10 coasts
    cyc(175);
    chk("pre coast off", 8'h00, {7'h00, coast});
    cyc(30);
    chk("pre coast on", 8'h01, {7'h00, coast});
    apb(1'b0, IDX_STAT, 8'h00);
    chk("pol detect", 8'h01, {7'h00, rd[0]});
    tally_and_finish();
  end
  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule : clamp_coast_power_control_test

// >>> logic/ccpc_pkg.sv
// ccpc_pkg: shared constants and types for the clamp, coast and power block
package ccpc_pkg;
  // ------------------------------------------------------------
  // clock rates and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned SEP_TICK_HZ = 5000000;
  localparam int unsigned SEP_DIV = CLK_HZ / SEP_TICK_HZ;
  localparam logic [4:0] SEP_DIV_LAST = 5'(SEP_DIV - 1);
  localparam int unsigned SYNC_IDLE_US = 100;
  localparam int unsigned SYNC_IDLE_CYC = SYNC_IDLE_US * (CLK_HZ / 1000000);

  // ------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h0F;
  localparam logic [7:0] IDX_SLICE = 8'h10;
  localparam logic [7:0] IDX_SEPLIM = 8'h11;
  localparam logic [7:0] IDX_LEAD = 8'h12;
  localparam logic [7:0] IDX_TRAIL = 8'h13;
  localparam logic [7:0] IDX_STAT = 8'h14;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;
  localparam logic [23:0] RD_PAD = 24'h000000;

  // ------------------------------------------------------------
  // reset values and write masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h4E;
  localparam logic [7:0] RST_SLICE = 8'h78;
  localparam logic [7:0] RST_SEPLIM = 8'h20;
  localparam logic [7:0] RST_LEAD = 8'h00;
  localparam logic [7:0] RST_TRAIL = 8'h00;
  localparam logic [7:0] WMASK_LOW0 = 8'hFE;

  // ------------------------------------------------------------
  // internal clamp window, in clock cycles after line start
  // ------------------------------------------------------------
  localparam logic [7:0] CLAMP_PLACE = 8'h08;
  localparam logic [7:0] CLAMP_DUR = 8'h14;

  // ------------------------------------------------------------
  // pin slots and counter widths
  // ------------------------------------------------------------
  localparam int unsigned PIN_LINE = 0;
  localparam int unsigned PIN_FRAME = 1;
  localparam int unsigned PIN_GREEN = 2;
  localparam int unsigned PIN_CLAMP = 3;
  localparam int unsigned PIN_COAST = 4;
  localparam int unsigned PIN_N = 5;
  localparam int unsigned LEN_W = 16;
  localparam int unsigned LINE_W = 12;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic clamp_ext;
    logic clamp_act_low;
    logic coast_frame;
    logic coast_ovr;
    logic coast_pol_high;
    logic seek_en;
    logic run;
    logic spare;
  } ccpc_ctrl_t;

  typedef struct packed {
    logic [4:0] code;
    logic red_mid;
    logic blue_mid;
    logic spare;
  } ccpc_slice_t;

  typedef struct packed {
    logic line_sync;
    logic frame_sync;
    logic [1:0] pix_clk;
    logic [47:0] data;
  } ccpc_vout_t;

  typedef enum logic [2:0] {
    PW_RUN = 3'h1,
    PW_SEEK = 3'h2,
    PW_DOWN = 3'h4
  } ccpc_pw_t;

  typedef enum logic [2:0] {
    CL_IDLE = 3'h1,
    CL_WAIT = 3'h2,
    CL_ON = 3'h4
  } ccpc_cl_t;
endpackage : ccpc_pkg

// >>> logic/ccpc_sync_sep.sv
// ccpc_sync_sep: sync separator counting slow ticks before each toggle
`timescale 1ns/1ps
module ccpc_sync_sep (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // slow tick, sliced sync and count limit
  input wire logic tick,
  input wire logic level,
  input wire logic [7:0] limit,
  // separated sync
  output logic sep_out
);
  import ccpc_pkg::*;

  logic [7:0] cnt;
  logic out_q;
  wire differs = level != out_q;
  wire reached = cnt == limit;

  // RULE_12 count then toggle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 8'h00;
      out_q <= 1'b0;
    end else if (!differs) begin
      cnt <= 8'h00;
    end else if (tick) begin
      if (reached) begin
        out_q <= level;
        cnt <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  assign sep_out = out_q;

  property p_sep_toggle;
    @(posedge clk) disable iff (!nrst)
    tick && differs && reached |=> out_q == $past(level);
  endproperty
  a_sep_toggle: assert property (p_sep_toggle) else $error("separator missed toggle"); // RULE_12

  property p_sep_hold;
    @(posedge clk) disable iff (!nrst)
    differs && !reached |=> out_q == $past(out_q);
  endproperty
  a_sep_hold: assert property (p_sep_hold) else $error("separator toggled early"); // RULE_12
endmodule : ccpc_sync_sep

// >>> logic/ccpc_top.sv
// ccpc_top: clamp, coast and power control with its register bank on APB
`timescale 1ns/1ps
// What this block does
// RULE_01: with clamp source 0, clamp timing comes from internal counters started by line sync.
// RULE_02: with clamp source 1, clamp timing follows the external clamp pin.
// RULE_03: bit 6 sets external clamp polarity (0 high, 1 low) and matters only for external clamp.
// RULE_04: bit 5 picks the coast source, 0 the coast pin and 1 frame sync.
// RULE_05: bit 4 picks automatic coast polarity (0) or the polarity in bit 3 (1).
// RULE_06: bit 3 gives coast polarity (1 high) and acts only for the pin source with override set.
// RULE_07: bit 2 allows seek low-power mode while sync inputs are idle, tri-stating outputs.
// RULE_08: bit 1 at 0 powers the block down, at 1 it runs normally.
// RULE_09: in power-down and seek, video outputs float while green sync and sync logic keep running.
// RULE_10: a 5-bit slicer threshold code sits in bits 7:3, 10 mV a step from 10 mV.
// RULE_11: bits 2 and 1 clamp red and blue to ground (0) or their midscale reference (1).
// RULE_12: the separator counts 5 MHz ticks up to an 8-bit limit, 32 at reset, before toggling.
// RULE_13: software should set the separator limit above the widest line or equalising pulse.
// RULE_14: with frame sync as coast source, coast starts the set number of lines before frame sync.
// RULE_15: with frame sync as coast source, coast holds the set number of lines after it ends.
// RULE_16: automatic mode detects coast signal polarity and reports it in a status bit.
// RULE_17: bit 0 of the control and slicer registers ignores writes and reads zero.
module ccpc_top #(
  parameter int unsigned IDLE_CYCLES = ccpc_pkg::SYNC_IDLE_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // sync and control pins
  input wire logic LINE_SYNC_IN,
  input wire logic FRAME_SYNC_IN,
  input wire logic GREEN_SYNC_INPUT,
  input wire logic CLAMP_IN,
  input wire logic COAST_IN,
  // video outputs, three-state
  input wire ccpc_pkg::ccpc_vout_t VOUT_IN,
  output ccpc_pkg::ccpc_vout_t VOUT_O,
  output ccpc_pkg::ccpc_vout_t VOUT_OE,
  output logic GREEN_SYNC_OUTPUT,
  // analog and pll controls
  output logic CLAMP_ACTIVE,
  output logic RED_MIDSCALE_REF_SEL,
  output logic BLUE_MIDSCALE_REF_SEL,
  output logic [4:0] SLICER_CODE,
  output logic PLL_COAST,
  output logic SEP_SYNC_OUT,
  output logic SEEK_MODE,
  output logic FULL_POWER_DOWN
);
  import ccpc_pkg::*;

  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == ADDR_ALIGN) && (addr[9:2] == idx);
  endfunction : hit

  function automatic logic act(input logic lvl, input logic act_high);
    act = act_high ? lvl : !lvl;
  endfunction : act

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  ccpc_ctrl_t ctrl;
  ccpc_slice_t slice;
  logic [7:0] sep_lim;
  logic [7:0] lead;
  logic [7:0] trail;
  logic det_pol;
  logic err_q;

  wire setup = PSEL && !PENABLE;
  wire access = PSEL && PENABLE;
  wire mapped = hit(PADDR, IDX_CTRL) || hit(PADDR, IDX_SLICE) || hit(PADDR, IDX_SEPLIM)
    || hit(PADDR, IDX_LEAD) || hit(PADDR, IDX_TRAIL) || hit(PADDR, IDX_STAT);
  wire wr = access && PWRITE && !err_q;
  wire [7:0] wbyte = PWDATA[7:0];
  wire [7:0] rd_byte = hit(PADDR, IDX_CTRL) ? ctrl
    : hit(PADDR, IDX_SLICE) ? slice
    : hit(PADDR, IDX_SEPLIM) ? sep_lim
    : hit(PADDR, IDX_LEAD) ? lead
    : hit(PADDR, IDX_TRAIL) ? trail
    : hit(PADDR, IDX_STAT) ? {7'h00, det_pol} : 8'h00;

  // RULE_17 spare bits masked
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl <= ccpc_ctrl_t'(RST_CTRL);
      slice <= ccpc_slice_t'(RST_SLICE);
      sep_lim <= RST_SEPLIM;
      lead <= RST_LEAD;
      trail <= RST_TRAIL;
    end else if (wr) begin
      if (hit(PADDR, IDX_CTRL)) ctrl <= ccpc_ctrl_t'(wbyte & WMASK_LOW0);
      if (hit(PADDR, IDX_SLICE)) slice <= ccpc_slice_t'(wbyte & WMASK_LOW0);
      if (hit(PADDR, IDX_SEPLIM)) sep_lim <= wbyte;
      if (hit(PADDR, IDX_LEAD)) lead <= wbyte;
      if (hit(PADDR, IDX_TRAIL)) trail <= wbyte;
    end
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h00000000;
      err_q <= 1'b0;
    end else if (setup) begin
      PRDATA <= {RD_PAD, rd_byte};
      err_q <= !mapped;
    end
  end

  assign PREADY = access;
  assign PSLVERR = access && err_q;

  // RULE_10 slicer code out
  assign SLICER_CODE = slice.code;
  // RULE_11 midscale selects
  assign RED_MIDSCALE_REF_SEL = slice.red_mid;
  assign BLUE_MIDSCALE_REF_SEL = slice.blue_mid;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [PIN_N-1:0] raw = {COAST_IN, CLAMP_IN, GREEN_SYNC_INPUT, FRAME_SYNC_IN, LINE_SYNC_IN};
  logic [PIN_N-1:0] s1;
  logic [PIN_N-1:0] s2;
  logic [PIN_N-1:0] s3;
  logic [PIN_N-1:0] clean;

  for (genvar gi = 0; gi < PIN_N; gi++) begin : g_sync
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        s1[gi] <= 1'b0;
        s2[gi] <= 1'b0;
        s3[gi] <= 1'b0;
        clean[gi] <= 1'b0;
      end else begin
        s1[gi] <= raw[gi];
        s2[gi] <= s1[gi];
        s3[gi] <= s2[gi];
        if (s2[gi] == s3[gi]) clean[gi] <= s3[gi];
      end
    end
  end

  logic [PIN_N-1:0] prev;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) prev <= '0;
    else prev <= clean;
  end

  // line periods are marked by the rising edge, whatever the polarity
  wire line_edge = clean[PIN_LINE] && !prev[PIN_LINE];
  wire sync_edge = (clean[PIN_LINE] != prev[PIN_LINE]) || (clean[PIN_FRAME] != prev[PIN_FRAME]);

  // RULE_09 green sync stays live
  assign GREEN_SYNC_OUTPUT = clean[PIN_GREEN];

  // ------------------------------------------------------------
  // sync separator with 5 MHz tick
  // ------------------------------------------------------------
  logic [4:0] div;
  wire tick = div == SEP_DIV_LAST;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) div <= 5'h00;
    else div <= tick ? 5'h00 : div + 5'h01;
  end

  ccpc_sync_sep u_sep (
    .clk(CLK),
    .nrst(NRST),
    .tick(tick),
    .level(clean[PIN_GREEN]),
    .limit(sep_lim),
    .sep_out(SEP_SYNC_OUT)
  );

  // ------------------------------------------------------------
  // clamp timing
  // ------------------------------------------------------------
  ccpc_cl_t cl_st;
  ccpc_cl_t next_cl_st;
  logic [7:0] cl_cnt;
  wire place_done = cl_cnt == CLAMP_PLACE - 8'h01;
  wire dur_done = cl_cnt == CLAMP_DUR - 8'h01;

  always_comb begin
    next_cl_st = cl_st;
    case (cl_st)
      CL_IDLE: next_cl_st = CL_IDLE;
      CL_WAIT: if (place_done) next_cl_st = CL_ON;
      CL_ON: if (dur_done) next_cl_st = CL_IDLE;
      default: next_cl_st = CL_IDLE;
    endcase
    if (line_edge) next_cl_st = CL_WAIT;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cl_st <= CL_IDLE;
      cl_cnt <= 8'h00;
    end else begin
      cl_st <= next_cl_st;
      cl_cnt <= (next_cl_st != cl_st || line_edge) ? 8'h00 : cl_cnt + 8'h01;
    end
  end

  // RULE_01 RULE_02 RULE_03 clamp source
  wire ext_clamp = act(clean[PIN_CLAMP], !ctrl.clamp_act_low);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) CLAMP_ACTIVE <= 1'b0;
    else CLAMP_ACTIVE <= ctrl.clamp_ext ? ext_clamp : (cl_st == CL_ON);
  end

  // ------------------------------------------------------------
  // coast polarity detection
  // ------------------------------------------------------------
  wire csrc = ctrl.coast_frame ? clean[PIN_FRAME] : clean[PIN_COAST];
  wire csrc_prev = ctrl.coast_frame ? prev[PIN_FRAME] : prev[PIN_COAST];
  logic [LEN_W-1:0] run_len;
  logic [LEN_W-1:0] hi_len;
  logic [LEN_W-1:0] lo_len;
  wire src_edge = csrc != csrc_prev;

  // RULE_16 shorter level is active
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_len <= '0;
      hi_len <= '0;
      lo_len <= '0;
      det_pol <= 1'b0;
    end else begin
      if (src_edge) begin
        run_len <= '0;
        if (csrc_prev) hi_len <= run_len;
        else lo_len <= run_len;
      end else if (run_len != '1) begin
        run_len <= run_len + 1'b1;
      end
      det_pol <= hi_len < lo_len;
    end
  end

  // RULE_05 RULE_06 polarity choice
  wire pin_pol = ctrl.coast_ovr ? ctrl.coast_pol_high : det_pol;
  wire pin_coast = act(clean[PIN_COAST], pin_pol);
  wire frame_act = act(clean[PIN_FRAME], det_pol);

  // ------------------------------------------------------------
  // pre and post coast windows in line periods
  // ------------------------------------------------------------
  logic frame_q;
  logic [LINE_W-1:0] lines;
  logic [LINE_W-1:0] frame_lines;
  logic [7:0] post_cnt;
  wire frame_start = frame_act && !frame_q;
  wire frame_end = !frame_act && frame_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      frame_q <= 1'b0;
      lines <= '0;
      frame_lines <= '0;
    end else begin
      frame_q <= frame_act;
      if (frame_start) begin
        frame_lines <= lines;
        lines <= '0;
      end else if (line_edge && lines != '1) begin
        lines <= lines + 1'b1;
      end
    end
  end

  // RULE_14 predicted from last frame
  wire [LINE_W:0] lines_ahead = {1'b0, lines} + {5'h00, lead};
  // strict compare: lead lines of coast, not lead plus one
  wire pre_win = (lead != 8'h00) && (frame_lines != '0) && (lines_ahead > {1'b0, frame_lines});

  // RULE_15 hold after frame sync
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) post_cnt <= 8'h00;
    else if (frame_end) post_cnt <= trail;
    else if (frame_act) post_cnt <= 8'h00;
    else if (line_edge && post_cnt != 8'h00) post_cnt <= post_cnt - 8'h01;
  end
  wire post_win = post_cnt != 8'h00;

  // RULE_04 coast source select
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) PLL_COAST <= 1'b0;
    else PLL_COAST <= ctrl.coast_frame ? (frame_act || pre_win || post_win) : pin_coast;
  end

  // ------------------------------------------------------------
  // power modes
  // ------------------------------------------------------------
  logic [LEN_W-1:0] idle_cnt;
  wire sync_idle = idle_cnt == LEN_W'(IDLE_CYCLES - 1);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) idle_cnt <= '0;
    else if (sync_edge) idle_cnt <= '0;
    else if (!sync_idle) idle_cnt <= idle_cnt + 1'b1;
  end

  ccpc_pw_t pw_st;
  ccpc_pw_t next_pw_st;

  // RULE_07 RULE_08 mode control
  always_comb begin
    next_pw_st = pw_st;
    case (pw_st)
      PW_RUN: if (ctrl.seek_en && sync_idle) next_pw_st = PW_SEEK;
      PW_SEEK: if (!ctrl.seek_en || !sync_idle) next_pw_st = PW_RUN;
      PW_DOWN: next_pw_st = PW_RUN;
      default: next_pw_st = PW_RUN;
    endcase
    if (!ctrl.run) next_pw_st = PW_DOWN;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) pw_st <= PW_RUN;
    else pw_st <= next_pw_st;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) VOUT_O <= '0;
    else VOUT_O <= VOUT_IN;
  end

  // RULE_09 outputs float off-run
  assign VOUT_OE = (pw_st == PW_RUN) ? '1 : '0;
  assign SEEK_MODE = pw_st == PW_SEEK;
  assign FULL_POWER_DOWN = pw_st == PW_DOWN;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_int_clamp;
    !ctrl.clamp_ext |=> CLAMP_ACTIVE == ($past(cl_st) == CL_ON);
  endproperty
  a_int_clamp: assert property (p_int_clamp) else $error("internal clamp wrong"); // RULE_01

  property p_ext_clamp;
    ctrl.clamp_ext && !ctrl.clamp_act_low |=> CLAMP_ACTIVE == $past(clean[PIN_CLAMP]);
  endproperty
  a_ext_clamp: assert property (p_ext_clamp) else $error("external clamp wrong"); // RULE_02

  property p_clamp_low;
    ctrl.clamp_ext && ctrl.clamp_act_low |=> CLAMP_ACTIVE != $past(clean[PIN_CLAMP]);
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("clamp polarity wrong"); // RULE_03

  property p_coast_ovr;
    !ctrl.coast_frame && ctrl.coast_ovr
      |=> PLL_COAST == ($past(clean[PIN_COAST]) == $past(ctrl.coast_pol_high));
  endproperty
  a_coast_ovr: assert property (p_coast_ovr) else $error("coast override wrong"); // RULE_06

  property p_coast_auto;
    NRST && !ctrl.coast_frame && !ctrl.coast_ovr
      |=> PLL_COAST == ($past(clean[PIN_COAST]) == $past(det_pol));
  endproperty
  a_coast_auto: assert property (p_coast_auto) else $error("auto coast wrong"); // RULE_05

  property p_pre;
    ctrl.coast_frame && pre_win |=> PLL_COAST;
  endproperty
  a_pre: assert property (p_pre) else $error("pre-coast missing"); // RULE_14

  property p_post;
    ctrl.coast_frame && frame_end && trail != 8'h00 |=> post_win ##1 PLL_COAST;
  endproperty
  a_post: assert property (p_post) else $error("post-coast missing"); // RULE_15

  property p_seek_gate;
    pw_st != PW_SEEK && !ctrl.seek_en |=> pw_st != PW_SEEK;
  endproperty
  a_seek_gate: assert property (p_seek_gate) else $error("seek entered while barred"); // RULE_07

  property p_down;
    !ctrl.run |=> pw_st == PW_DOWN && VOUT_OE == '0;
  endproperty
  a_down: assert property (p_down) else $error("power-down not taken"); // RULE_08

  property p_float;
    pw_st != PW_RUN |-> VOUT_OE == '0 && GREEN_SYNC_OUTPUT == clean[PIN_GREEN];
  endproperty
  a_float: assert property (p_float) else $error("outputs driven off-run"); // RULE_09

  property p_slice_wr;
    wr && hit(PADDR, IDX_SLICE)
      |=> SLICER_CODE == $past(PWDATA[7:3]) && RED_MIDSCALE_REF_SEL == $past(PWDATA[2])
      && BLUE_MIDSCALE_REF_SEL == $past(PWDATA[1]);
  endproperty
  a_slice_wr: assert property (p_slice_wr) else $error("slicer write lost"); // RULE_11

  property p_spare_rd;
    setup && (hit(PADDR, IDX_CTRL) || hit(PADDR, IDX_SLICE)) |=> PRDATA[0] == 1'b0;
  endproperty
  a_spare_rd: assert property (p_spare_rd) else $error("spare bit reads one"); // RULE_17

  property p_stat_rd;
    setup && hit(PADDR, IDX_STAT) |=> PRDATA[0] == $past(det_pol);
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("polarity status wrong"); // RULE_16
endmodule : ccpc_top
